// >>> design/delay_calibrator.sv
`timescale 1ns/100ps
module delay_calibrator #(
  parameter int unsigned REF_CYC = dcal_pkg::REF_PERIOD_CYC,
  parameter int unsigned RDY_CYC = dcal_pkg::RDY_TIME_CYC
) (
  input  wire logic              i_clk,
  input  wire logic              i_nrst,
  input  wire dcal_pkg::cal_in_t i_ctl,
  output dcal_pkg::cal_out_t     o_stat
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    dcal_pkg::cal_state_t             st;
    logic                             rst_q;
    logic                             ref_q;
    logic [dcal_pkg::CNT_W-1:0]       idle_cnt;
    logic [dcal_pkg::CNT_W-1:0]       lat_cnt;
    logic [dcal_pkg::CNT_W-1:0]       per_cnt;
    logic                             measured;
    logic [dcal_pkg::CAL_W-1:0]       cal_word;
    logic                             rdy;
  } cal_reg_t;

  localparam logic [dcal_pkg::CNT_W-1:0] REF_LIM =
    dcal_pkg::CNT_W'(REF_CYC);
  localparam logic [dcal_pkg::CNT_W-1:0] RDY_LIM =
    dcal_pkg::CNT_W'(RDY_CYC);

  cal_reg_t s_ff;
  cal_reg_t nxt_s;
  logic     ref_rise;
  logic     ref_edge;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_s    = s_ff;
    ref_rise = i_ctl.ref_clk & ~s_ff.ref_q;
    ref_edge = i_ctl.ref_clk ^ s_ff.ref_q;
    nxt_s.rst_q = i_ctl.rst;
    nxt_s.ref_q = i_ctl.ref_clk;
    // stall watch runs on the system clock so it sees a dead reference
    if (ref_edge) begin
      nxt_s.idle_cnt = dcal_pkg::CNT_RST;
    end else if (s_ff.idle_cnt != REF_LIM) begin
      nxt_s.idle_cnt = s_ff.idle_cnt + 1'b1;
    end
    // period measurement is the calibration word for the region taps
    if (ref_rise) begin
      nxt_s.per_cnt  = dcal_pkg::CNT_RST;
      // the edge cycle itself belongs to the period, hence the one
      nxt_s.cal_word = s_ff.per_cnt[dcal_pkg::CAL_W-1:0] + 8'h01;
      nxt_s.measured = 1'b1;
    end else if (s_ff.per_cnt != {dcal_pkg::CNT_W{1'b1}}) begin
      nxt_s.per_cnt = s_ff.per_cnt + 1'b1;
    end
    case (s_ff.st)
      dcal_pkg::ST_HOLD: begin
        nxt_s.rdy = 1'b0;
        nxt_s.lat_cnt  = dcal_pkg::CNT_RST;
        nxt_s.measured = 1'b0;
        if (!i_ctl.rst) begin
          nxt_s.st = dcal_pkg::ST_CAL;
        end
      end
      dcal_pkg::ST_CAL: begin
        if (s_ff.lat_cnt != RDY_LIM) begin
          nxt_s.lat_cnt = s_ff.lat_cnt + 1'b1;
        end
        if (s_ff.lat_cnt == RDY_LIM && s_ff.measured) begin
          nxt_s.st  = dcal_pkg::ST_READY;
          nxt_s.rdy = 1'b1;
        end
      end
      dcal_pkg::ST_READY: begin
        // calibration keeps tracking; only a dead reference or the reset input drops ready
        if (s_ff.idle_cnt == REF_LIM) begin
          nxt_s.st  = dcal_pkg::ST_STALL;
          nxt_s.rdy = 1'b0;
        end
      end
      dcal_pkg::ST_STALL: begin
        // stays down until the fabric resets the calibrator
        nxt_s.rdy = 1'b0;
      end
      default: begin
        nxt_s.st  = dcal_pkg::ST_HOLD;
        nxt_s.rdy = 1'b0;
      end
    endcase
    if (s_ff.st == dcal_pkg::ST_CAL &&
        s_ff.idle_cnt == REF_LIM) begin
      nxt_s.measured = 1'b0;
      nxt_s.lat_cnt  = dcal_pkg::CNT_RST;
    end
    // a rising reset edge restarts; a held high level keeps it parked
    if (i_ctl.rst) begin
      nxt_s.st  = dcal_pkg::ST_HOLD;
      nxt_s.rdy = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      s_ff <= '{st: dcal_pkg::ST_HOLD, rst_q: 1'b0, ref_q: 1'b0,
                idle_cnt: dcal_pkg::CNT_RST, lat_cnt: dcal_pkg::CNT_RST,
                per_cnt: dcal_pkg::CNT_RST, measured: 1'b0,
                cal_word: dcal_pkg::CAL_RST, rdy: 1'b0};
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign o_stat.rdy      = s_ff.rdy;
  assign o_stat.cal_word = s_ff.cal_word;

endmodule

// >>> design/dcal_pkg.sv
package dcal_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS      = 40;
  // reference period that the calibrator expects (ref_clock_freq)
  localparam int unsigned REF_PERIOD_NS      = 200;
  localparam int unsigned REF_PERIOD_CYC     =
    (REF_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // reset_to_ready_time, least time so rounded up
  localparam int unsigned RDY_TIME_NS        = 3200;
  localparam int unsigned RDY_TIME_CYC       =
    (RDY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // widths and reset values
  // ----------------------------------------------------------------
  localparam int unsigned CNT_W              = 12;
  localparam int unsigned CAL_W              = 8;
  localparam logic [CAL_W-1:0] CAL_RST       = 8'h00;
  localparam logic [CNT_W-1:0] CNT_RST       = 12'h000;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic rst;
    logic ref_clk;
  } cal_in_t;

  typedef struct packed {
    logic             rdy;
    logic [CAL_W-1:0] cal_word;
  } cal_out_t;

  typedef enum logic [1:0] {
    ST_HOLD,
    ST_CAL,
    ST_READY,
    ST_STALL
  } cal_state_t;

endpackage

// >>> design/delay_calibration_controller.sv
// Function
// - reset input is active high and needs no reference clock edge
// - a rising reset edge restarts calibration; ready falls with it
// - the reference clock is the time base for every region's tap delays
// - ready goes high once the region's tap delays are calibrated
// - ready drops when the reference stays high or low a full period
// - ready rises only after the reset-to-ready latency has elapsed
// - one calibrator per region serves every tap delay of that region
// - replicas share the reset and reference of the unplaced original
// - used ready is the AND of original and all replica readies
// - when ready is ignored the replica readies stay unconnected
// - replicas go only into regions without a placed calibrator
// - placed calibrators keep their own reset, reference and ready
// - calibration runs continuously against process, voltage, temperature
`timescale 1ns/100ps
module delay_calibration_controller #(
  parameter int unsigned    N_REGIONS   = 4,
  // bit r set: region r holds a placement-constrained calibrator
  parameter logic [31:0]    PLACED_MASK = 32'h0000_0000,
  // 1: the unplaced calibrator's ready is used
  parameter bit             RDY_USED    = 1'b1,
  parameter int unsigned    REF_CYC     = dcal_pkg::REF_PERIOD_CYC,
  parameter int unsigned    RDY_CYC     = dcal_pkg::RDY_TIME_CYC
) (
  input  wire logic                          i_clk,
  input  wire logic                          i_nrst,
  input  wire dcal_pkg::cal_in_t             i_ctl,
  input  wire dcal_pkg::cal_in_t [N_REGIONS-1:0] i_placed_ctl,
  output logic                               o_rdy,
  output logic [N_REGIONS-1:0]               o_placed_rdy,
  output logic [N_REGIONS-1:0][dcal_pkg::CAL_W-1:0] o_cal_word
);

  // ----------------------------------------------------------------
  // regional calibrators
  // ----------------------------------------------------------------
  dcal_pkg::cal_out_t [N_REGIONS-1:0] reg_stat;
  logic [N_REGIONS-1:0]               repl_rdy;
  logic [N_REGIONS-1:0]               plc_rdy;

  genvar r;
  generate
    for (r = 0; r < N_REGIONS; r++) begin : g_region
      dcal_pkg::cal_in_t sel_ctl;
      // placed ones keep private wiring; others take the shared pair
      assign sel_ctl = PLACED_MASK[r] ? i_placed_ctl[r]
                                      : i_ctl;
      // exactly one calibrator per region drives that region's taps
      delay_calibrator #(
        .REF_CYC (REF_CYC),
        .RDY_CYC (RDY_CYC)
      ) u_cal (
        .i_clk  (i_clk),
        .i_nrst (i_nrst),
        .i_ctl  (sel_ctl),
        .o_stat (reg_stat[r])
      );
      // a replica only lands where no placed one sits
      assign repl_rdy[r] = PLACED_MASK[r] ? 1'b1
                                          : reg_stat[r].rdy;
      assign plc_rdy[r]  = PLACED_MASK[r] ? reg_stat[r].rdy : 1'b0;
    end
  endgenerate

  // ----------------------------------------------------------------
  // output registers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                                       rdy;
    logic [N_REGIONS-1:0]                       plc;
    logic [N_REGIONS-1:0][dcal_pkg::CAL_W-1:0]  cal;
  } top_reg_t;

  top_reg_t t_ff;
  top_reg_t nxt_t;
  logic     any_repl;

  always_comb begin
    nxt_t    = t_ff;
    any_repl = ~&PLACED_MASK[N_REGIONS-1:0];
    // one gate as wide as the region count; placed slots read as 1
    if (RDY_USED && any_repl) begin
      nxt_t.rdy = &repl_rdy;
    end else begin
      nxt_t.rdy = 1'b0;
    end
    nxt_t.plc = plc_rdy;
    for (int i = 0; i < N_REGIONS; i++) begin
      nxt_t.cal[i] = reg_stat[i].cal_word;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      t_ff <= '0;
    end else begin
      t_ff <= nxt_t;
    end
  end

  assign o_rdy        = t_ff.rdy;
  assign o_placed_rdy = t_ff.plc;
  assign o_cal_word   = t_ff.cal;

endmodule

// >>> tb/dcal_chk.sv
`timescale 1ns/100ps
// --------------------------------------------------
// checker beside the controller
// --------------------------------------------------
module dcal_chk #(
  parameter int unsigned N_REGIONS   = 4,
  parameter logic [31:0] PLACED_MASK = 32'h0000_0000,
  parameter int unsigned REF_CYC     = 5,
  parameter int unsigned RDY_CYC     = 8,
  parameter bit          RDY_USED    = 1'b1
) (
  input  wire logic                              i_clk,
  input  wire logic                              i_nrst,
  input  wire dcal_pkg::cal_in_t                 i_ctl,
  input  wire dcal_pkg::cal_in_t [N_REGIONS-1:0] i_placed_ctl,
  input  wire logic                              o_rdy,
  input  wire logic [N_REGIONS-1:0]              o_placed_rdy
);
  logic [N_REGIONS-1:0] prst;
  logic                 ref_ff;
  logic                 stl_ff;
  logic [7:0]           idle_ff;
  logic [7:0]           since_ff;
  logic [7:0]           ok_ff;
  always_comb begin
    for (int r = 0; r < N_REGIONS; r++) begin
      prst[r] = i_placed_ctl[r].rst;
    end
  end
  // counters saturate so a long run never wraps into a false pass
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ref_ff   <= 1'b0;
      stl_ff   <= 1'b0;
      idle_ff  <= 8'h00;
      since_ff <= 8'h00;
      ok_ff    <= 8'h00;
    end else begin
      ref_ff   <= i_ctl.ref_clk;
      stl_ff   <= !i_ctl.rst && (stl_ff || idle_ff >= REF_CYC);
      idle_ff  <= (i_ctl.ref_clk != ref_ff) ? 8'h00 :
                  idle_ff + 8'(idle_ff != 8'hFF);
      since_ff <= i_ctl.rst ? 8'h00 : since_ff + 8'(since_ff != 8'hFF);
      // any pause of the reference voids the ready promise
      ok_ff    <= (i_ctl.rst || stl_ff || idle_ff > 8'h01) ? 8'h00 :
                  ok_ff + 8'(ok_ff != 8'hFF);
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  reset_clears_a: assert property (disable iff (1'b0)
    !i_nrst |-> !o_rdy && o_placed_rdy == '0) else $error("ready in reset");
  rst_blocks_rdy_a: assert property (
    o_rdy |-> !$past(i_ctl.rst, 2)) else $error("ready during reset");
  latency_min_a: assert property (
    o_rdy |-> since_ff > RDY_CYC) else $error("ready too early");
  ready_arrives_a: assert property (
    RDY_USED && ok_ff >= RDY_CYC + 8 |-> o_rdy) else $error("ready missing");
  ignored_low_a: assert property (
    !RDY_USED |-> !o_rdy) else $error("ignored ready driven");
  stall_drops_a: assert property (
    idle_ff >= REF_CYC |-> ##[0:4] !o_rdy) else $error("stall kept ready");
  restart_drop_a: assert property (
    $rose(i_ctl.rst) |-> ##2 !o_rdy [*2]) else $error("ready survived reset");
  placed_only_a: assert property (
    (o_placed_rdy & ~PLACED_MASK[N_REGIONS-1:0]) == '0)
    else $error("ready on unplaced region");
  placed_rst_a: assert property (
    (o_placed_rdy & $past(prst, 2)) == '0) else $error("placed ready in reset");
endmodule

bind delay_calibration_controller dcal_chk #(
  .N_REGIONS  (N_REGIONS),
  .PLACED_MASK(PLACED_MASK),
  .REF_CYC    (REF_CYC),
  .RDY_CYC    (RDY_CYC),
  .RDY_USED   (RDY_USED)
) i_chk (
  .i_clk       (i_clk),
  .i_nrst      (i_nrst),
  .i_ctl       (i_ctl),
  .i_placed_ctl(i_placed_ctl),
  .o_rdy       (o_rdy),
  .o_placed_rdy(o_placed_rdy)
);

// >>> tb/fabric_model.sv
`timescale 1ns/100ps
// --------------------------------------------------
// fabric side: reset pulse and reference clock
// --------------------------------------------------
module fabric_model (
  input  wire logic         i_clk,
  input  wire logic         i_nrst,
  input  wire logic         i_pulse,
  input  wire logic         i_hold,
  output dcal_pkg::cal_in_t o_ctl
);
  logic ph_ff;
  // reset stays high through system reset so no calibration starts blind
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_ctl <= '{rst: 1'b1, ref_clk: 1'b0};
      ph_ff <= 1'b0;
    end else begin
      o_ctl.rst <= i_pulse;
      if (!i_hold) begin
        ph_ff <= ~ph_ff;
        o_ctl.ref_clk <= o_ctl.ref_clk ^ ph_ff;
      end
    end
  end
endmodule

// >>> tb/delay_calibration_controller_bench.sv
`timescale 1ns/100ps
module delay_calibration_controller_bench;
  // --------------------------------------------------
  // rows: {pulse_sh, hold_sh, pulse_pl, hold_pl}, wait, {rdy, placed1}
  // --------------------------------------------------
  typedef struct packed {
    logic [3:0] ctl;
    logic [7:0] wait_n;
    logic [1:0] want;
  } row_t;
  localparam int unsigned NR = 4;
  logic                                i_clk = 1'b0;
  logic                                i_nrst = 1'b1;
  logic                                rdy_ign;
  logic [3:0]                          ctl = 4'hA;
  dcal_pkg::cal_in_t                   sh_ctl;
  dcal_pkg::cal_in_t                   pl1;
  dcal_pkg::cal_in_t [NR-1:0]          pl_ctl;
  logic                                o_rdy;
  logic [NR-1:0]                       o_placed_rdy;
  logic [NR-1:0][dcal_pkg::CAL_W-1:0]  o_cal_word;
  int                                  miscompares = 0;
  int                                  comparisons = 0;
  row_t rows [10] = '{
    '{4'hA, 8'h03, 2'b00}, '{4'h0, 8'h06, 2'b00}, '{4'h0, 8'h0A, 2'b11},
    '{4'h4, 8'h0A, 2'b01}, '{4'h0, 8'h14, 2'b01}, '{4'h8, 8'h02, 2'b01},
    '{4'h0, 8'h14, 2'b11}, '{4'h1, 8'h0A, 2'b10}, '{4'h2, 8'h02, 2'b10},
    '{4'h0, 8'h14, 2'b11}};
  always #20 i_clk = ~i_clk;
  // regions 0, 2 and 3 have no placed calibrator: their placed inputs are tied low
  assign pl_ctl = {4'h0, pl1, 2'b00};
  // the unplaced calibrators of regions 0, 2 and 3 in both designs are all fed by f_sh
  fabric_model f_sh (.i_clk(i_clk), .i_nrst(i_nrst), .i_pulse(ctl[3]),
    .i_hold(ctl[2]), .o_ctl(sh_ctl));
  fabric_model f_pl (.i_clk(i_clk), .i_nrst(i_nrst), .i_pulse(ctl[1]),
    .i_hold(ctl[0]), .o_ctl(pl1));
  delay_calibration_controller #(.N_REGIONS(NR), .PLACED_MASK(32'h0000_0002),
    .RDY_USED(1'b1), .REF_CYC(5), .RDY_CYC(8)) i_dut (.i_clk(i_clk),
    .i_nrst(i_nrst), .i_ctl(sh_ctl), .i_placed_ctl(pl_ctl), .o_rdy(o_rdy),
    .o_placed_rdy(o_placed_rdy), .o_cal_word(o_cal_word));
  delay_calibration_controller #(.N_REGIONS(NR), .PLACED_MASK(32'h0000_0002),
    .RDY_USED(1'b0), .REF_CYC(5), .RDY_CYC(8)) i_dut_ign (.i_clk(i_clk),
    .i_nrst(i_nrst), .i_ctl(sh_ctl), .i_placed_ctl(pl_ctl), .o_rdy(rdy_ign),
    .o_placed_rdy(), .o_cal_word());
  task automatic step(input int n);
    repeat (n) @(posedge i_clk);
    #2;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    comparisons++;
    if (seen !== want) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // a hang in any wait ends up here
  initial begin
    #(40 * 3000);
    miscompares++;
    tally_and_finish();
  end
  initial begin
    #2 i_nrst = 1'b0;
    step(5);
    i_nrst = 1'b1;
    foreach (rows[i]) begin
      ctl = rows[i].ctl;
      step(int'(rows[i].wait_n));
      check(16'({o_rdy, o_placed_rdy}), 16'({rows[i].want[1], 2'b00,
        rows[i].want[0], 1'b0}));
      check(16'(rdy_ign), 16'h0000);
    end
    // reference runs at four system cycles per period
    check(16'(o_cal_word[0]), 16'h0004);
    check(16'(o_cal_word[3]), 16'h0004);
    check(16'(o_cal_word[1]), 16'h0004);
    i_nrst = 1'b0;
    #1 check(16'({o_rdy, o_placed_rdy}), 16'h0000);
    ctl = 4'hA;
    step(3);
    i_nrst = 1'b1;
    step(2);
    ctl = 4'h0;
    step(22);
    check(16'({o_rdy, o_placed_rdy}), 16'h0012);
    tally_and_finish();
  end
endmodule
